// ==== hw/asc_step_cfg.sv ====
// sequencer step setup registers of the auxiliary converter, axi4-lite slave
// assumes one clock, synchronous reset, bus master on the same clock
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module asc_step_cfg
    import asc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [asc_pkg::ASC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [asc_pkg::ASC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [asc_pkg::ASC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [asc_pkg::ASC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0] stepEnable,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0][2:0] stepGainFactor,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0][7:0] stepPosExternal,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0][asc_pkg::ASC_INT_W-1:0] stepPosInternal,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0] stepNegGround,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0] stepNegSeven,
    output logic [asc_pkg::ASC_STEP_COUNT-1:0] stepNegAuto
);
    import asc_pkg::*;

    typedef struct packed {
        asc_wr_state_type wrState;
        asc_rd_state_type rdState;
        logic [ASC_ADDR_W-1:0] awAddr;
        logic [ASC_DATA_W-1:0] wData;
        logic [3:0] wStrb;
        logic awReady;
        logic wReady;
        logic bValid;
        logic [1:0] bResp;
        logic arReady;
        logic rValid;
        logic [ASC_DATA_W-1:0] rData;
        logic [1:0] rResp;
        logic [ASC_STEP_COUNT-1:0][ASC_REG_W-1:0] stepCfg;
        logic [ASC_STEP_COUNT-1:0] stepOn;
        logic [ASC_STEP_COUNT-1:0][2:0] gain;
        logic [ASC_STEP_COUNT-1:0][7:0] posExt;
        logic [ASC_STEP_COUNT-1:0][ASC_INT_W-1:0] posInt;
        logic [ASC_STEP_COUNT-1:0] negGnd;
        logic [ASC_STEP_COUNT-1:0] negSev;
        logic [ASC_STEP_COUNT-1:0] negAut;
    } asc_state_type;

    asc_state_type st_r;
    asc_state_type st_nxt;

    // decoded fields of each step
    logic [ASC_STEP_COUNT-1:0] decOn;
    logic [ASC_STEP_COUNT-1:0][2:0] decGain;
    logic [ASC_STEP_COUNT-1:0][7:0] decPosExt;
    logic [ASC_STEP_COUNT-1:0][ASC_INT_W-1:0] decPosInt;
    logic [ASC_STEP_COUNT-1:0] decNegGnd;
    logic [ASC_STEP_COUNT-1:0] decNegSev;
    logic [ASC_STEP_COUNT-1:0] decNegAut;

    // handshakes
    logic awTake;
    logic wTake;
    logic arTake;
    logic doWrite;
    logic [ASC_ADDR_W-1:0] wrAddr;
    logic [ASC_DATA_W-1:0] wrData;
    logic [3:0] wrStrb;
    logic [ASC_STEP_COUNT-1:0] wrHit;
    logic [ASC_STEP_COUNT-1:0] rdHit;
    logic [ASC_STEP_COUNT-1:0][9:0] stepIdx;
    logic [ASC_STEP_COUNT-1:0][ASC_REG_W-1:0] stepReset;

    // index and reset value of each step register
    assign stepIdx[0] = ASC_STEP2_IDX;
    assign stepIdx[1] = ASC_STEP3_IDX;
    assign stepReset[0] = ASC_STEP2_RESET;
    assign stepReset[1] = ASC_STEP3_RESET;

    genvar gi;
    generate
        for (gi = 0; gi < ASC_STEP_COUNT; gi++)
        begin : g_step
            asc_step_decode u_dec (
                .stepCfg(st_r.stepCfg[gi]),
                .stepOn(decOn[gi]),
                .gainFactor(decGain[gi]),
                .posExternal(decPosExt[gi]),
                .posInternal(decPosInt[gi]),
                .negGround(decNegGnd[gi]),
                .negSeven(decNegSev[gi]),
                .negAuto(decNegAut[gi])
            );
            // word address compare, byte address is index times four
            assign wrHit[gi] = (wrAddr[ASC_ADDR_W-1:2] == stepIdx[gi]);
            assign rdHit[gi] = (s_axi_araddr[ASC_ADDR_W-1:2] == stepIdx[gi]);
        end
    endgenerate

    // merge one write into a register through byte strobes
    function automatic logic [ASC_REG_W-1:0] mergeWrite(
        input logic [ASC_REG_W-1:0] oldVal,
        input logic [ASC_DATA_W-1:0] newVal,
        input logic [3:0] strb
    );
        logic [ASC_REG_W-1:0] res;
        res = oldVal;
        if (strb[0])
        begin
            res[7:0] = newVal[7:0];
        end
        if (strb[1])
        begin
            res[15:8] = newVal[15:8];
        end
        // reserved bits never store
        return res & ASC_WRITE_MASK;
    endfunction

    always_comb
    begin
        awTake = s_axi_awvalid && st_r.awReady;
        wTake = s_axi_wvalid && st_r.wReady;
        arTake = s_axi_arvalid && st_r.arReady;
        wrAddr = (st_r.wrState == ASC_WR_ADDR) ? st_r.awAddr : s_axi_awaddr;
        wrData = (st_r.wrState == ASC_WR_DATA) ? st_r.wData : s_axi_wdata;
        wrStrb = (st_r.wrState == ASC_WR_DATA) ? st_r.wStrb : s_axi_wstrb;
        doWrite = 1'b0;
        st_nxt = st_r;

        // write channel: address and data in either order
        case (st_r.wrState)
            ASC_WR_IDLE:
            begin
                if (awTake && wTake)
                begin
                    doWrite = 1'b1;
                    st_nxt.wrState = ASC_WR_RESP;
                end
                else if (awTake)
                begin
                    st_nxt.awAddr = s_axi_awaddr;
                    st_nxt.wrState = ASC_WR_ADDR;
                end
                else if (wTake)
                begin
                    st_nxt.wData = s_axi_wdata;
                    st_nxt.wStrb = s_axi_wstrb;
                    st_nxt.wrState = ASC_WR_DATA;
                end
            end
            ASC_WR_ADDR:
            begin
                if (wTake)
                begin
                    doWrite = 1'b1;
                    st_nxt.wrState = ASC_WR_RESP;
                end
            end
            ASC_WR_DATA:
            begin
                if (awTake)
                begin
                    doWrite = 1'b1;
                    st_nxt.wrState = ASC_WR_RESP;
                end
            end
            ASC_WR_RESP:
            begin
                if (s_axi_bready)
                begin
                    st_nxt.wrState = ASC_WR_IDLE;
                end
            end
            default:
            begin
                st_nxt.wrState = ASC_WR_IDLE;
            end
        endcase

        // register update and write answer
        if (doWrite)
        begin
            st_nxt.bResp = (|wrHit) ? ASC_RESP_OKAY : ASC_RESP_SLVERR;
            for (int i = 0; i < ASC_STEP_COUNT; i++)
            begin
                if (wrHit[i])
                begin
                    st_nxt.stepCfg[i] = mergeWrite(st_r.stepCfg[i], wrData, wrStrb);
                end
            end
        end
        st_nxt.bValid = (st_nxt.wrState == ASC_WR_RESP);
        st_nxt.awReady = (st_nxt.wrState == ASC_WR_IDLE) || (st_nxt.wrState == ASC_WR_DATA);
        st_nxt.wReady = (st_nxt.wrState == ASC_WR_IDLE) || (st_nxt.wrState == ASC_WR_ADDR);

        // read channel
        case (st_r.rdState)
            ASC_RD_IDLE:
            begin
                if (arTake)
                begin
                    st_nxt.rData = '0;
                    st_nxt.rResp = ASC_RESP_SLVERR;
                    for (int i = 0; i < ASC_STEP_COUNT; i++)
                    begin
                        if (rdHit[i])
                        begin
                            // upper bits and reserved bits read zero
                            st_nxt.rData = {16'h0000, st_r.stepCfg[i] & ASC_WRITE_MASK};
                            st_nxt.rResp = ASC_RESP_OKAY;
                        end
                    end
                    st_nxt.rdState = ASC_RD_DATA;
                end
            end
            ASC_RD_DATA:
            begin
                if (s_axi_rready)
                begin
                    st_nxt.rdState = ASC_RD_IDLE;
                end
            end
            default:
            begin
                st_nxt.rdState = ASC_RD_IDLE;
            end
        endcase
        st_nxt.rValid = (st_nxt.rdState == ASC_RD_DATA);
        st_nxt.arReady = (st_nxt.rdState == ASC_RD_IDLE);

        // registered routing outputs
        st_nxt.stepOn = decOn;
        st_nxt.gain = decGain;
        st_nxt.posExt = decPosExt;
        st_nxt.posInt = decPosInt;
        st_nxt.negGnd = decNegGnd;
        st_nxt.negSev = decNegSev;
        st_nxt.negAut = decNegAut;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.wrState <= ASC_WR_IDLE;
            st_r.rdState <= ASC_RD_IDLE;
            st_r.awReady <= 1'b1;
            st_r.wReady <= 1'b1;
            st_r.arReady <= 1'b1;
            st_r.stepCfg[0] <= ASC_STEP2_RESET;
            st_r.stepCfg[1] <= ASC_STEP3_RESET;
        end
        else if (ce)
        begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign s_axi_awready = st_r.awReady;
    assign s_axi_wready = st_r.wReady;
    assign s_axi_bresp = st_r.bResp;
    assign s_axi_bvalid = st_r.bValid;
    assign s_axi_arready = st_r.arReady;
    assign s_axi_rdata = st_r.rData;
    assign s_axi_rresp = st_r.rResp;
    assign s_axi_rvalid = st_r.rValid;
    assign stepEnable = st_r.stepOn;
    assign stepGainFactor = st_r.gain;
    assign stepPosExternal = st_r.posExt;
    assign stepPosInternal = st_r.posInt;
    assign stepNegGround = st_r.negGnd;
    assign stepNegSeven = st_r.negSev;
    assign stepNegAuto = st_r.negAut;

endmodule // asc_step_cfg

// ==== hw/asc_step_decode.sv ====
// decodes one step setup word into routing and gain selects
// assumes a registered setup word; purely combinational
`timescale 1ns/1ps
module asc_step_decode
    import asc_pkg::*;
(
    input wire logic [asc_pkg::ASC_REG_W-1:0] stepCfg,
    output logic stepOn,
    output logic [2:0] gainFactor,
    output logic [7:0] posExternal,
    output logic [asc_pkg::ASC_INT_W-1:0] posInternal,
    output logic negGround,
    output logic negSeven,
    output logic negAuto
);
    logic [3:0] posCode;
    logic [1:0] gainCode;

    always_comb
    begin
        posCode = stepCfg[ASC_POS_HI:ASC_POS_LO];
        gainCode = stepCfg[ASC_GAIN_HI:ASC_GAIN_LO];
        stepOn = stepCfg[ASC_EN_BIT];
        // gain 1, 2, else 4
        case (gainCode)
            ASC_GAIN_CODE_X1: gainFactor = ASC_GAIN_X1;
            ASC_GAIN_CODE_X2: gainFactor = ASC_GAIN_X2;
            default: gainFactor = ASC_GAIN_X4;
        endcase
        posExternal = '0;
        posInternal = '0;
        if (!posCode[3])
        begin
            posExternal[posCode[2:0]] = 1'b1;
        end
        else
        begin
            case (posCode)
                ASC_POS_TEMP_A: posInternal[ASC_INT_TEMP] = 1'b1;
                ASC_POS_SHORT: posInternal[ASC_INT_SHORT] = 1'b1;
                ASC_POS_DAC_B: posInternal[ASC_INT_DAC] = 1'b1;
                ASC_POS_PWR_DIV: posInternal[ASC_INT_PWR] = 1'b1;
                default: posInternal[ASC_INT_OTHER] = 1'b1;
            endcase
        end
        // internal sources pick the negative input themselves
        negAuto = posCode[3];
        negSeven = !posCode[3] && stepCfg[ASC_NEG_BIT];
        negGround = !posCode[3] && !stepCfg[ASC_NEG_BIT];
    end
endmodule // asc_step_decode

// ==== include/asc_pkg.sv ====
// constants for the auxiliary converter sequencer step setup registers
// assumes a 32-bit axi4-lite slave, word-aligned registers, 12-bit byte address
package asc_pkg;

    // bus geometry
    localparam int ASC_ADDR_W = 12;
    localparam int ASC_DATA_W = 32;
    localparam int ASC_REG_W = 16;
    localparam int ASC_STEP_COUNT = 2;

    // register indices; byte address is four times the index
    localparam logic [9:0] ASC_STEP2_IDX = 10'h092;
    localparam logic [9:0] ASC_STEP3_IDX = 10'h093;

    // reset values
    localparam logic [15:0] ASC_STEP2_RESET = 16'h0002;
    localparam logic [15:0] ASC_STEP3_RESET = 16'h0003;

    // field positions
    localparam int ASC_EN_BIT = 15;
    localparam int ASC_GAIN_HI = 14;
    localparam int ASC_GAIN_LO = 13;
    localparam int ASC_NEG_BIT = 4;
    localparam int ASC_POS_HI = 3;
    localparam int ASC_POS_LO = 0;
    localparam logic [15:0] ASC_WRITE_MASK = 16'hE01F;

    // gain codes and factors
    localparam logic [1:0] ASC_GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] ASC_GAIN_CODE_X2 = 2'h1;
    localparam logic [2:0] ASC_GAIN_X1 = 3'h1;
    localparam logic [2:0] ASC_GAIN_X2 = 3'h2;
    localparam logic [2:0] ASC_GAIN_X4 = 3'h4;

    // positive input codes
    localparam logic [3:0] ASC_POS_TEMP_A = 4'h8;
    localparam logic [3:0] ASC_POS_SHORT = 4'h9;
    localparam logic [3:0] ASC_POS_DAC_B = 4'hA;
    localparam logic [3:0] ASC_POS_PWR_DIV = 4'hE;

    // internal source one-hot outputs
    localparam int ASC_INT_W = 5;
    localparam int ASC_INT_TEMP = 0;
    localparam int ASC_INT_SHORT = 1;
    localparam int ASC_INT_DAC = 2;
    localparam int ASC_INT_PWR = 3;
    localparam int ASC_INT_OTHER = 4;

    // axi responses
    localparam logic [1:0] ASC_RESP_OKAY = 2'h0;
    localparam logic [1:0] ASC_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ASC_WR_IDLE = 4'h1,
        ASC_WR_ADDR = 4'h2,
        ASC_WR_DATA = 4'h4,
        ASC_WR_RESP = 4'h8
    } asc_wr_state_type;

    typedef enum logic [1:0] {
        ASC_RD_IDLE = 2'h1,
        ASC_RD_DATA = 2'h2
    } asc_rd_state_type;

endpackage

// ==== tb/asc_step_cfg_props.sv ====
// checker for the step setup register block
// assumes one clock, synchronous active-high rst, bound into asc_step_cfg
`timescale 1ns/1ps
module asc_step_cfg_props
    import asc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [asc_pkg::ASC_DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [asc_pkg::ASC_STEP_COUNT-1:0][2:0] stepGainFactor,
    input wire logic [asc_pkg::ASC_STEP_COUNT-1:0][7:0] stepPosExternal,
    input wire logic [asc_pkg::ASC_STEP_COUNT-1:0][asc_pkg::ASC_INT_W-1:0] stepPosInternal,
    input wire logic [asc_pkg::ASC_STEP_COUNT-1:0] stepNegGround,
    input wire logic [asc_pkg::ASC_STEP_COUNT-1:0] stepNegSeven,
    input wire logic [asc_pkg::ASC_STEP_COUNT-1:0] stepNegAuto
);
    logic wTake;
    logic rTake;
    logic primed;
    // routing outputs hold a decode once an enabled edge follows reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            primed <= 1'b0;
        end
        else if (ce)
        begin
            primed <= 1'b1;
        end
    end
    assign wTake = ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rTake = ce && s_axi_arvalid && s_axi_arready;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_wr_answer: assert property (wTake |=> s_axi_bvalid)
        else $error("write response did not follow");
    chk_rd_answer: assert property (rTake |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response did not follow");
    chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response not held");
    chk_resv_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12:5] == 8'h00)
        else $error("reserved read bits not zero");
    for (genvar i = 0; i < ASC_STEP_COUNT; i++)
    begin : g_step
        chk_auto_neg: assert property (stepNegAuto[i] |-> !stepNegGround[i] && !stepNegSeven[i])
            else $error("manual negative select under auto code");
        chk_int_src: assert property (stepNegAuto[i] |-> $onehot(stepPosInternal[i]) && stepPosExternal[i] == 8'h00)
            else $error("internal source not one-hot");
        chk_ext_neg: assert property (stepPosExternal[i] != 8'h00 |-> stepNegGround[i] ^ stepNegSeven[i])
            else $error("external input without one negative select");
        chk_gain_set: assert property (primed |-> stepGainFactor[i] inside {3'h1, 3'h2, 3'h4})
            else $error("gain factor out of set");
    end
    cover property (wTake);
    cover property (rTake);
    cover property (stepNegAuto[0] && stepNegAuto[1]);
endmodule // asc_step_cfg_props

bind asc_step_cfg asc_step_cfg_props u_props (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .stepGainFactor(stepGainFactor),
    .stepPosExternal(stepPosExternal), .stepPosInternal(stepPosInternal), .stepNegGround(stepNegGround),
    .stepNegSeven(stepNegSeven), .stepNegAuto(stepNegAuto));

// ==== tb/asc_step_cfg_tb_top.sv ====
// self-checking bench for the step setup registers
// assumes asc_pkg, asc_step_cfg and its checker compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module asc_step_cfg_tb_top;
    import asc_pkg::*;
    logic clk, rst, ce, awValid, wValid, bReady, arValid, rReady, awReady, wReady, bValid, arReady, rValid;
    logic [1:0] bResp, rResp, stepEnable, stepNegGround, stepNegSeven, stepNegAuto;
    logic [11:0] awAddr, arAddr;
    logic [31:0] wData, rData, d;
    logic [3:0] wStrb;
    logic [1:0][2:0] stepGainFactor;
    logic [1:0][7:0] stepPosExternal;
    logic [1:0][4:0] stepPosInternal;
    logic [15:0] model [2];
    logic [11:0] addrs [3];
    int num_errors, comparisons;
    asc_step_cfg dut (.clk(clk), .rst(rst), .ce(ce), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .stepEnable(stepEnable),
        .stepGainFactor(stepGainFactor), .stepPosExternal(stepPosExternal), .stepPosInternal(stepPosInternal),
        .stepNegGround(stepNegGround), .stepNegSeven(stepNegSeven), .stepNegAuto(stepNegAuto));
    task automatic results();
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // write with model update; index 2 is an unmapped word
    task automatic regWrite(input int i, input logic [31:0] dv, input logic [3:0] s);
        logic [15:0] m;
        logic b;
        m = (i < 2) ? model[i] : 16'h0000;
        if (s[0]) m[7:0] = dv[7:0];
        if (s[1]) m[15:8] = dv[15:8];
        awAddr <= addrs[i];
        wData <= dv;
        wStrb <= s;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        b = 1'b0;
        for (int n = 0; n < 40 && !b; n++)
        begin
            @(posedge clk);
            if (awValid && awReady) awValid <= 1'b0;
            if (wValid && wReady) wValid <= 1'b0;
            if (bValid && bReady)
            begin
                b = 1'b1;
                bReady <= 1'b0;
                `CHK(bResp, (i < 2) ? ASC_RESP_OKAY : ASC_RESP_SLVERR)
            end
        end
        if (!b)
        begin
            num_errors++;
            results();
        end
        if (i < 2) model[i] = m & 16'hE01F;
        @(posedge clk);
    endtask
    task automatic regRead(input int i);
        logic r;
        arAddr <= addrs[i];
        arValid <= 1'b1;
        rReady <= 1'b1;
        r = 1'b0;
        for (int n = 0; n < 40 && !r; n++)
        begin
            @(posedge clk);
            if (arValid && arReady) arValid <= 1'b0;
            if (rValid && rReady)
            begin
                r = 1'b1;
                rReady <= 1'b0;
                `CHK(rData, (i < 2) ? {16'h0000, model[i]} : 32'h00000000)
                `CHK(rResp, (i < 2) ? ASC_RESP_OKAY : ASC_RESP_SLVERR)
            end
        end
        if (!r)
        begin
            num_errors++;
            results();
        end
        @(posedge clk);
    endtask
    task automatic checkSteps();
        logic [15:0] v;
        logic [7:0] ext;
        logic [4:0] inr;
        for (int i = 0; i < 2; i++)
        begin
            v = model[i];
            ext = v[3] ? 8'h00 : (8'h01 << v[2:0]);
            case (v[3:0])
                4'h8: inr = 5'h01;
                4'h9: inr = 5'h02;
                4'hA: inr = 5'h04;
                4'hE: inr = 5'h08;
                4'hB, 4'hC, 4'hD, 4'hF: inr = 5'h10;
                default: inr = 5'h00;
            endcase
            `CHK(stepEnable[i], v[15])
            `CHK(stepGainFactor[i], v[14] ? 3'h4 : {1'b0, v[13], !v[13]})
            `CHK(stepPosExternal[i], ext)
            `CHK(stepPosInternal[i], inr)
            `CHK(stepNegAuto[i], v[3])
            `CHK(stepNegSeven[i], !v[3] && v[4])
            `CHK(stepNegGround[i], !v[3] && !v[4])
        end
    endtask
    task automatic doReset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        ce <= 1'b0;
        model[0] = ASC_STEP2_RESET;
        model[1] = 16'h0003;
        // enable low keeps the reset state frozen
        repeat (3) @(posedge clk);
        `CHK({stepEnable, stepPosExternal, stepPosInternal, stepNegAuto}, 30'h0)
        `CHK(awReady && wReady && arReady && !bValid && !rValid, 1'b1)
        ce <= 1'b1;
        repeat (3) @(posedge clk);
        checkSteps();
        regRead(0);
        regRead(1);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        {rst, ce, awValid, wValid, bReady, arValid, rReady} = 7'h61;
        {awAddr, arAddr, wData, wStrb} = '0;
        addrs = '{12'h248, 12'h24C, 12'h250};
        num_errors = 0;
        comparisons = 0;
        void'($urandom(32'h7418B07E));
        doReset();
        // every positive code and gain code on both steps
        for (int k = 0; k < 32; k++)
        begin
            d = $urandom();
            d[3:0] = k[4:1];
            d[14:13] = k[2:1];
            regWrite(k % 2, d, 4'hF);
            regRead(k % 2);
            checkSteps();
        end
        // byte strobes, then unmapped word leaves both steps alone
        regWrite(0, $urandom(), 4'h1);
        regWrite(1, $urandom(), 4'h2);
        regWrite(0, $urandom(), 4'h0);
        regWrite(2, $urandom(), 4'hF);
        regRead(2);
        regRead(0);
        regRead(1);
        checkSteps();
        doReset();
        results();
    end
endmodule // asc_step_cfg_tb_top
